// *** hw/link_tx_regs.vh ***
// Purpose: register offsets, fields, reset values and timing counts for the packet link transmit controller
// Assumes: APB, 32-bit data, one aligned word per register, pclk at 50 MHz
// Notes: definitions only
`ifndef LINK_TX_REGS_VH
`define LINK_TX_REGS_VH

// register byte offsets
`define CTRL_OFF 12'h000
`define KEYUP_OFF 12'h004
`define BEACON_OFF 12'h008
`define MAX_PACKET_LENGTH_OFF 12'h00C
`define DEST_OFF 12'h010
`define STATUS_OFF 12'h014
`define TXDATA_OFF 12'h018
`define CALL_OFF 12'h01C
`define GREET_OFF 12'h020
`define RXDATA_OFF 12'h024

// control bits
`define C_IDENT 0
`define C_RELAY 1
`define C_ACCEPT 2
`define C_GREET 3
`define C_PERMIT 4
`define C_BEVERY 5
`define C_BAFTER 6
`define C_TRANSP 7
`define C_SENDINC 8
`define C_LINEFEED_INSERT_ENABLE 9
`define C_V2 10
`define C_BYPASS 11
`define C_TRACE 12
`define C_HALT 13
`define C_FINALID 14
`define C_GREETCLR 15
`define CTRL_RESET 32'h0000041E

// keyup register fields: delay [7:0], extra [15:8], hang [23:16]
`define KEYUP_RESET 32'h00000000
// beacon register: count of 10 s intervals [15:0]
`define BEACON_RESET 32'h00000000
`define MAX_PACKET_LENGTH_RESET 32'h00000080
// destination callsign packed as ascii, default "CQ"
`define DEST_RESET 32'h00004351

// timing
`define CLK_HZ 50000000
`define TICK_MS 10
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define TICKS_PER_10S 1000
`define IDENT_TICKS 57000
`define GREET_DEPTH 120
`define LF_BYTE 8'h0A
`define CR_BYTE 8'h0D
`define FLAG_BYTE 8'h7E

`endif

// *** hw/packet_link_tx_controller.v ***
// Purpose: transmit keying, packet sizing, beacon/ident and connect control for a packet radio link
// Assumes: APB slave, one clock, link side presents bytes and channel events as one-cycle pulses
// Notes: frame check and retry timing live elsewhere; this block decides when and what to send
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "link_tx_regs.vh"

module packet_link_tx_controller (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on address above the last register
  input wire chan_busy, // carrier detect level
  input wire rx_byte_valid, // received byte strobe
  input wire [7:0] rx_byte, // received byte
  input wire rx_frame_start, // flag seen at frame start
  input wire rx_frame_end, // frame end strobe
  input wire rx_crc_ok, // frame check result at end
  input wire rx_bits_whole, // frame held whole bytes
  input wire rx_connect_req, // connect request pulse
  input wire rx_busy_reject, // busy rejection pulse
  input wire rx_relay_req, // frame routed through this station
  input wire tx_done, // modem finished current frame
  output reg ptt, // transmitter key
  output reg tx_valid, // byte to modem valid
  output reg [7:0] tx_byte, // byte to modem
  output reg tx_flag_fill, // sending sync flags
  output reg relay_go, // retransmit the relayed frame
  output reg reject_send, // send busy rejection
  output reg accept_send, // send connect acknowledge
  output reg connected, // link up
  output reg [2:0] pkt_kind, // 0 data 1 ident 2 beacon 3 greeting
  output reg frame_accept, // monitored frame accepted
  output reg term_valid, // byte to terminal
  output reg [7:0] term_byte // terminal byte
);
  localparam S_IDLE = 4'b0001;
  localparam S_KEY = 4'b0010;
  localparam S_DATA = 4'b0100;
  localparam S_WAIT = 4'b1000;

  reg [31:0] ctrl_reg;
  reg [31:0] keyup_reg;
  reg [31:0] beacon_reg;
  reg [31:0] max_packet_length_reg;
  reg [31:0] dest_reg;
  reg [3:0] state_reg;
  reg [19:0] div_reg;
  reg tick_reg;
  reg [8:0] key_cnt_reg;
  reg [7:0] hang_cnt_reg;
  reg [15:0] id_cnt_reg;
  reg [15:0] bsec_reg;
  reg [15:0] bcnt_reg;
  reg relayed_reg;
  reg id_pend_reg;
  reg bcn_pend_reg;
  reg greet_pend_reg;
  reg heard_reg;
  reg [7:0] buf_mem [0:255];
  reg [7:0] buf_wr_reg;
  reg [7:0] buf_rd_reg;
  reg [7:0] buf_len_reg;
  reg send_pend_reg;
  reg lf_pend_reg;
  reg [7:0] greet_mem [0:`GREET_DEPTH-1];
  reg [6:0] greet_len_reg;
  reg [6:0] greet_idx_reg;
  reg [7:0] mon_mem [0:255];
  reg [7:0] mon_wr_reg;
  reg [7:0] mon_rd_reg;
  reg [7:0] caller_reg;
  reg [2:0] hex_ph_reg;
  reg [7:0] hex_byte_reg;
  reg busy_rep_reg;

  wire wr = psel & penable & pwrite;
  wire rd = psel & ~penable & ~pwrite;
  wire [7:0] max_packet_length = max_packet_length_reg[7:0];

  // nibble to ascii hex digit
  function [7:0] hex_char;
    input [3:0] n;
    begin
      hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
  endfunction

  // apb: zero wait states, offsets above the last register answer with an error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `RXDATA_OFF);
      if (rd) begin
        case (paddr)
          `CTRL_OFF: prdata <= ctrl_reg;
          `KEYUP_OFF: prdata <= keyup_reg;
          `BEACON_OFF: prdata <= beacon_reg;
          `MAX_PACKET_LENGTH_OFF: prdata <= max_packet_length_reg;
          `DEST_OFF: prdata <= dest_reg;
          `STATUS_OFF: prdata <= {16'h0000, caller_reg, 1'b0, busy_rep_reg, relayed_reg, connected, state_reg};
          `CALL_OFF: prdata <= {24'h000000, caller_reg};
          `RXDATA_OFF: prdata <= {23'h000000, mon_wr_reg != mon_rd_reg, mon_mem[mon_rd_reg]};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // configuration registers; final ident and greeting clear are self-clearing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      keyup_reg <= `KEYUP_RESET;
      beacon_reg <= `BEACON_RESET;
      max_packet_length_reg <= `MAX_PACKET_LENGTH_RESET;
      dest_reg <= `DEST_RESET;
    end else begin
      ctrl_reg[`C_FINALID] <= 1'b0;
      ctrl_reg[`C_GREETCLR] <= 1'b0;
      if (wr && paddr == `CTRL_OFF) ctrl_reg <= pwdata;
      if (wr && paddr == `KEYUP_OFF) keyup_reg <= {8'h00, pwdata[23:0]};
      if (wr && paddr == `BEACON_OFF) beacon_reg <= {16'h0000, pwdata[15:0]};
      if (wr && paddr == `MAX_PACKET_LENGTH_OFF) max_packet_length_reg <= {24'h000000, pwdata[7:0]};
      if (wr && paddr == `DEST_OFF) dest_reg <= pwdata;
    end
  end

  // greeting store; a pass-prefixed carriage return arrives as a plain data byte here
  always @(posedge pclk) begin
    if (wr && paddr == `GREET_OFF && greet_len_reg < `GREET_DEPTH) greet_mem[greet_len_reg] <= pwdata[7:0];
  end

  // 10 ms tick and every interval counter hang off it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 20'h00000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == `TICK_CYCLES - 1);
      div_reg <= (div_reg == `TICK_CYCLES - 1) ? 20'h00000 : div_reg + 20'h00001;
    end
  end

  // session, relay, ident and beacon bookkeeping
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      connected <= 1'b0;
      relay_go <= 1'b0;
      reject_send <= 1'b0;
      accept_send <= 1'b0;
      caller_reg <= 8'h00;
      busy_rep_reg <= 1'b0;
      relayed_reg <= 1'b0;
      id_cnt_reg <= 16'h0000;
      id_pend_reg <= 1'b0;
      bsec_reg <= 16'h0000;
      bcnt_reg <= 16'h0000;
      bcn_pend_reg <= 1'b0;
      heard_reg <= 1'b0;
      hang_cnt_reg <= 8'h00;
      greet_pend_reg <= 1'b0;
      greet_len_reg <= 7'h00;
    end else begin
      relay_go <= rx_relay_req & ctrl_reg[`C_RELAY];
      if (rx_relay_req && ctrl_reg[`C_RELAY]) relayed_reg <= 1'b1;
      reject_send <= rx_connect_req & ~ctrl_reg[`C_ACCEPT];
      accept_send <= rx_connect_req & ctrl_reg[`C_ACCEPT] & ~connected;
      if (rx_connect_req && !ctrl_reg[`C_ACCEPT]) caller_reg <= rx_byte;
      if (rx_connect_req && ctrl_reg[`C_ACCEPT] && !connected) begin
        connected <= 1'b1;
        greet_pend_reg <= ctrl_reg[`C_GREET] & (greet_len_reg != 7'h00);
      end
      if (rx_busy_reject) begin
        connected <= 1'b0;
        busy_rep_reg <= 1'b1;
        caller_reg <= rx_byte;
      end
      if (ctrl_reg[`C_GREETCLR]) greet_len_reg <= 7'h00;
      else if (wr && paddr == `GREET_OFF && greet_len_reg < `GREET_DEPTH) greet_len_reg <= greet_len_reg + 7'h01;
      if (state_reg == S_DATA && pkt_kind == 3'd3 && greet_idx_reg == greet_len_reg - 7'h01 && tx_valid)
        greet_pend_reg <= 1'b0;
      // hang window restarts on every sign of channel activity
      if (chan_busy) hang_cnt_reg <= keyup_reg[23:16];
      else if (tick_reg && hang_cnt_reg != 8'h00) hang_cnt_reg <= hang_cnt_reg - 8'h01;
      // pending clears come first so a request landing in the same cycle wins
      if (state_reg == S_WAIT && pkt_kind == 3'd1) id_pend_reg <= 1'b0;
      if (tick_reg && ctrl_reg[`C_IDENT] && relayed_reg) begin
        if (id_cnt_reg == `IDENT_TICKS - 1) begin
          id_cnt_reg <= 16'h0000;
          id_pend_reg <= 1'b1;
        end else id_cnt_reg <= id_cnt_reg + 16'h0001;
      end
      if (ctrl_reg[`C_FINALID] && relayed_reg) id_pend_reg <= 1'b1;
      if (state_reg == S_WAIT && pkt_kind == 3'd2) bcn_pend_reg <= 1'b0;
      // beacon interval in 10 s steps
      if (tick_reg) bsec_reg <= (bsec_reg == `TICKS_PER_10S - 1) ? 16'h0000 : bsec_reg + 16'h0001;
      if (tick_reg && bsec_reg == `TICKS_PER_10S - 1 && ctrl_reg[`C_BEVERY] && beacon_reg[15:0] != 16'h0000) begin
        if (bcnt_reg >= beacon_reg[15:0] - 16'h0001) begin
          bcnt_reg <= 16'h0000;
          bcn_pend_reg <= 1'b1;
        end else bcnt_reg <= bcnt_reg + 16'h0001;
      end
      // after-mode: activity arms, quiet for the beacon count of 10 s fires
      if (chan_busy) begin
        heard_reg <= 1'b1;
        if (ctrl_reg[`C_BAFTER]) bcnt_reg <= 16'h0000;
      end else if (tick_reg && bsec_reg == `TICKS_PER_10S - 1 && ctrl_reg[`C_BAFTER] && heard_reg) begin
        if (bcnt_reg >= beacon_reg[15:0] - 16'h0001) begin
          bcn_pend_reg <= 1'b1;
          heard_reg <= 1'b0;
          bcnt_reg <= 16'h0000;
        end else bcnt_reg <= bcnt_reg + 16'h0001;
      end
    end
  end

  // outgoing data buffer and send triggers
  wire tx_wr = wr && paddr == `TXDATA_OFF;
  wire is_send = pwdata[8];
  wire keep = ~is_send | ctrl_reg[`C_SENDINC];
  wire pop = state_reg == S_DATA && pkt_kind == 3'd0 && !lf_pend_reg && tx_valid;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wr_reg <= 8'h00;
      buf_len_reg <= 8'h00;
      send_pend_reg <= 1'b0;
    end else begin
      if (tx_wr && keep && buf_len_reg < max_packet_length) begin
        buf_wr_reg <= buf_wr_reg + 8'h01;
        buf_len_reg <= buf_len_reg + 8'h01 - {7'h00, pop};
      end else if (pop) buf_len_reg <= buf_len_reg - 8'h01;
      // full packet goes at once, as does any write with the send bit set
      if (tx_wr && (is_send || buf_len_reg + 8'h01 >= max_packet_length)) send_pend_reg <= 1'b1;
      else if (state_reg == S_WAIT && pkt_kind == 3'd0) send_pend_reg <= 1'b0;
    end
  end
  always @(posedge pclk) begin
    if (tx_wr && keep && buf_len_reg < max_packet_length) buf_mem[buf_wr_reg] <= pwdata[7:0];
  end

  // transmit sequencer
  wire [8:0] key_total = (hang_cnt_reg != 8'h00) ? {1'b0, keyup_reg[7:0]} :
                         {1'b0, keyup_reg[7:0]} + {1'b0, keyup_reg[15:8]};
  wire want = send_pend_reg | id_pend_reg | bcn_pend_reg | greet_pend_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      ptt <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      tx_flag_fill <= 1'b0;
      key_cnt_reg <= 9'h000;
      pkt_kind <= 3'd0;
      buf_rd_reg <= 8'h00;
      greet_idx_reg <= 7'h00;
      lf_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          tx_valid <= 1'b0;
          if (want && ctrl_reg[`C_PERMIT] && !chan_busy) begin
            ptt <= 1'b1;
            key_cnt_reg <= key_total;
            pkt_kind <= greet_pend_reg ? 3'd3 : id_pend_reg ? 3'd1 : bcn_pend_reg ? 3'd2 : 3'd0;
            greet_idx_reg <= 7'h00;
            state_reg <= S_KEY;
          end
        end
        S_KEY: begin
          tx_flag_fill <= 1'b1;
          tx_valid <= 1'b1;
          tx_byte <= `FLAG_BYTE;
          // a zero keyup count goes straight to data instead of waiting a whole tick
          if (key_cnt_reg == 9'h000 || (tick_reg && key_cnt_reg == 9'h001)) begin
            tx_flag_fill <= 1'b0;
            tx_valid <= 1'b0;
            state_reg <= S_DATA;
          end else if (tick_reg) key_cnt_reg <= key_cnt_reg - 9'h001;
        end
        S_DATA: begin
          tx_valid <= 1'b1;
          if (pkt_kind == 3'd0) begin
            if (lf_pend_reg) begin
              tx_byte <= `LF_BYTE;
              lf_pend_reg <= 1'b0;
            end else if (buf_len_reg == 8'h00 || (tx_valid && buf_len_reg == 8'h01)) begin
              tx_valid <= 1'b0;
              state_reg <= S_WAIT;
            end else begin
              tx_byte <= buf_mem[buf_rd_reg];
              buf_rd_reg <= buf_rd_reg + 8'h01;
              lf_pend_reg <= ctrl_reg[`C_LINEFEED_INSERT_ENABLE] && buf_mem[buf_rd_reg] == `CR_BYTE;
            end
          end else if (pkt_kind == 3'd3) begin
            tx_byte <= greet_mem[greet_idx_reg];
            greet_idx_reg <= greet_idx_reg + 7'h01;
            if (greet_idx_reg == greet_len_reg - 7'h01) state_reg <= S_WAIT;
          end else begin
            // ident and beacon carry the low byte of the destination word as their only byte
            tx_byte <= dest_reg[7:0];
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          tx_valid <= 1'b0;
          if (tx_done) begin
            ptt <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // monitor path: frame filter, trace expansion and stop-halted buffering
  wire mon_take = psel & penable & ~pwrite & (paddr == `RXDATA_OFF) & (mon_wr_reg != mon_rd_reg);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_accept <= 1'b0;
      mon_wr_reg <= 8'h00;
      mon_rd_reg <= 8'h00;
      term_valid <= 1'b0;
      term_byte <= 8'h00;
      hex_ph_reg <= 3'd0;
      hex_byte_reg <= 8'h00;
    end else begin
      frame_accept <= rx_frame_end & (ctrl_reg[`C_BYPASS] ? rx_bits_whole : rx_crc_ok);
      if (rx_byte_valid && (mon_wr_reg + 8'h01) != mon_rd_reg) begin
        mon_mem[mon_wr_reg] <= rx_byte;
        mon_wr_reg <= mon_wr_reg + 8'h01;
      end
      term_valid <= 1'b0;
      if (mon_take) mon_rd_reg <= mon_rd_reg + 8'h01;
      else if (!ctrl_reg[`C_HALT] && mon_wr_reg != mon_rd_reg) begin
        if (!ctrl_reg[`C_TRACE]) begin
          term_valid <= 1'b1;
          term_byte <= mon_mem[mon_rd_reg];
          mon_rd_reg <= mon_rd_reg + 8'h01;
        end else begin
          // trace: high digit, low digit, then the ascii byte itself
          term_valid <= 1'b1;
          case (hex_ph_reg)
            3'd0: term_byte <= hex_char(mon_mem[mon_rd_reg][7:4]);
            3'd1: term_byte <= hex_char(mon_mem[mon_rd_reg][3:0]);
            default: term_byte <= mon_mem[mon_rd_reg];
          endcase
          hex_byte_reg <= mon_mem[mon_rd_reg];
          if (hex_ph_reg == 3'd2) begin
            hex_ph_reg <= 3'd0;
            mon_rd_reg <= mon_rd_reg + 8'h01;
          end else hex_ph_reg <= hex_ph_reg + 3'd1;
        end
      end
    end
  end

  // version select and transparent mode are unused; the link timeout lives with the retry timers
  wire unused_ok = rx_frame_start | ctrl_reg[`C_V2] | ctrl_reg[`C_TRANSP] | (|hex_byte_reg);
endmodule // packet_link_tx_controller
`default_nettype wire

// *** verif/link_tx_checker_asserts.sv ***
// Purpose: port checks for the link transmit controller
// Assumes: one pclk domain, presetn async low
// Notes: bound to the controller below
`timescale 1ns/1ps
`default_nettype none
`include "link_tx_regs.vh"
module link_tx_checker (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // select
  input wire penable, // enable
  input wire pready, // ready
  input wire pslverr, // error
  input wire rx_connect_req, // connect pulse
  input wire rx_busy_reject, // reject pulse
  input wire rx_relay_req, // relay pulse
  input wire rx_frame_end, // frame end
  input wire accept_send, // acknowledge
  input wire reject_send, // busy answer
  input wire relay_go, // retransmit
  input wire connected, // link up
  input wire ptt, // key
  input wire tx_valid, // byte valid
  input wire [7:0] tx_byte, // byte
  input wire tx_flag_fill, // fill
  input wire frame_accept // accepted
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ack; accept_send |-> $past(rx_connect_req) && !reject_send; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge without request");
  property p_rej; reject_send |-> $past(rx_connect_req) && !accept_send; endproperty
  a_rej: assert property (p_rej) else $error("busy answer without request");
  property p_drop; rx_busy_reject |-> ##[1:2] !connected; endproperty
  a_drop: assert property (p_drop) else $error("link kept after reject");
  property p_relay; relay_go |-> $past(rx_relay_req); endproperty
  a_relay: assert property (p_relay) else $error("relay without frame");
  property p_fill; tx_flag_fill |-> ptt; endproperty
  a_fill: assert property (p_fill) else $error("fill while unkeyed");
  property p_flag; tx_flag_fill && tx_valid |-> tx_byte == `FLAG_BYTE; endproperty
  a_flag: assert property (p_flag) else $error("fill byte not a flag");
  property p_key; tx_valid |-> ptt; endproperty
  a_key: assert property (p_key) else $error("byte sent unkeyed");
  property p_facc; frame_accept |-> $past(rx_frame_end); endproperty
  a_facc: assert property (p_facc) else $error("accept without frame end");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  c_ack: cover property (accept_send);
  c_rej: cover property (reject_send);
  c_relay: cover property (relay_go);
  c_facc: cover property (frame_accept);
endmodule // link_tx_checker
bind packet_link_tx_controller link_tx_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .rx_connect_req(rx_connect_req),
  .rx_busy_reject(rx_busy_reject), .rx_relay_req(rx_relay_req), .rx_frame_end(rx_frame_end),
  .accept_send(accept_send), .reject_send(reject_send), .relay_go(relay_go), .connected(connected),
  .ptt(ptt), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_flag_fill(tx_flag_fill),
  .frame_accept(frame_accept));
`default_nettype wire

// *** verif/far_station.sv ***
// Purpose: stations across the channel, plus the modem
// Assumes: events are one-cycle pulses
// Notes: byte lines show the inverse between events
`timescale 1ns/1ps
`default_nettype none
module far_station (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic ptt, // key
  input wire logic tx_valid, // byte valid
  input wire logic tx_flag_fill, // fill
  input wire logic [7:0] tx_byte, // byte
  output logic tx_done, // frame sent
  output logic chan_busy, // carrier
  output logic [5:0] ev_o, // relay busy conn start end byte
  output logic [1:0] chk_o, // crc ok, whole bytes
  output logic [7:0] rx_byte // byte or caller
);
  logic [7:0] cap[$];
  int npkt = 0;
  int lag = 2;
  int idle = 0;
  logic got = 1'b0;
  initial begin
    chan_busy = 1'b0;
    ev_o = 6'h00;
    chk_o = 2'b00;
    rx_byte = 8'hA5;
  end
  // lag sets how long the modem takes to finish a frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_done <= 1'b0;
      got <= 1'b0;
      idle <= 0;
    end else begin
      tx_done <= 1'b0;
      if (tx_valid && !tx_flag_fill) begin
        cap.push_back(tx_byte);
        got <= 1'b1;
        idle <= 0;
      end else if (got && ptt) begin
        idle <= idle + 1;
      end
      if (got && ptt && idle == lag) begin
        tx_done <= 1'b1;
        got <= 1'b0;
        npkt <= npkt + 1;
      end
    end
  end
  task automatic ev(input logic [5:0] k, input logic [7:0] b, input logic [1:0] q);
    @(posedge pclk);
    ev_o <= k;
    chk_o <= q;
    rx_byte <= b;
    @(posedge pclk);
    ev_o <= 6'h00;
    chk_o <= ~q;
    rx_byte <= ~b;
  endtask
endmodule // far_station
`default_nettype wire

// *** verif/packet_link_tx_controller_tb.sv ***
// Purpose: register, session, packet and monitor tests
// Assumes: 10 ms tick too slow to reach, keyup kept at 0
// Notes: far_station plays the channel and modem
`timescale 1ns/1ps
`default_nettype none
`include "link_tx_regs.vh"
module packet_link_tx_controller_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdv;
  logic erv;
  logic [7:0] last_term;
  wire [31:0] prdata;
  wire [7:0] tx_byte, term_byte, rx_byte;
  wire [5:0] ev;
  wire [1:0] q;
  wire [2:0] pkt_kind;
  wire pready, pslverr, chan_busy, tx_done, ptt, tx_valid, tx_flag_fill, relay_go, reject_send;
  wire accept_send, connected, frame_accept, term_valid;
  int n_mismatch = 0, n_compared = 0, n_relay = 0, n_rej = 0, n_term = 0, n_facc = 0, n_key = 0, t0;
  packet_link_tx_controller dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_busy(chan_busy), .rx_byte_valid(ev[0]), .rx_byte(rx_byte), .rx_frame_start(ev[2]),
    .rx_frame_end(ev[1]), .rx_crc_ok(q[1]), .rx_bits_whole(q[0]), .rx_connect_req(ev[3]),
    .rx_busy_reject(ev[4]), .rx_relay_req(ev[5]), .tx_done(tx_done), .ptt(ptt), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_flag_fill(tx_flag_fill), .relay_go(relay_go), .reject_send(reject_send),
    .accept_send(accept_send), .connected(connected), .pkt_kind(pkt_kind), .frame_accept(frame_accept),
    .term_valid(term_valid), .term_byte(term_byte));
  far_station fm_u (.pclk(pclk), .presetn(presetn), .ptt(ptt), .tx_valid(tx_valid),
    .tx_flag_fill(tx_flag_fill), .tx_byte(tx_byte), .tx_done(tx_done), .chan_busy(chan_busy),
    .ev_o(ev), .chk_o(q), .rx_byte(rx_byte));
  initial begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (relay_go === 1'b1) n_relay++;
    if (reject_send === 1'b1) n_rej++;
    if (frame_accept === 1'b1) n_facc++;
    if (ptt === 1'b1) n_key++;
    if (term_valid === 1'b1) begin
      n_term++;
      last_term = term_byte;
    end
  end
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo;
    n_mismatch++;
    $display("BAD wait expired");
    conclude();
  endtask
  // one transfer; the task starts and ends one edge apart from its neighbours
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) tmo();
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv & m);
  endtask
  task automatic wait2;
    repeat (2) @(posedge pclk);
  endtask
  // words w are 9-bit entries, first in the low bits; expected bytes e likewise
  task automatic send(input logic [31:0] c, input logic [31:0] pl, input logic [26:0] w, input int nw,
    input logic [31:0] e, input int ne);
    int b, n0, i;
    b = fm_u.cap.size();
    n0 = fm_u.npkt;
    apb(1'b1, `CTRL_OFF, c);
    apb(1'b1, `MAX_PACKET_LENGTH_OFF, pl);
    for (i = 0; i < nw; i++) apb(1'b1, `TXDATA_OFF, {23'h0, w[9*i +: 9]});
    for (i = 0; i < 3000 && fm_u.npkt == n0; i++) @(posedge pclk);
    if (fm_u.npkt == n0) tmo();
    chk("tx count", 32'(ne), 32'(fm_u.cap.size() - b));
    for (i = 0; i < ne; i++) chk("tx byte", {24'h0, e[8*i +: 8]}, {24'h0, fm_u.cap[b + i]});
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", `CTRL_OFF, 32'h0000FFFF, `CTRL_RESET);
    rchk("keyup", `KEYUP_OFF, 32'hFFFFFFFF, `KEYUP_RESET);
    rchk("beacon", `BEACON_OFF, 32'hFFFFFFFF, `BEACON_RESET);
    rchk("max_packet_length", `MAX_PACKET_LENGTH_OFF, 32'hFFFFFFFF, `MAX_PACKET_LENGTH_RESET);
    rchk("dest", `DEST_OFF, 32'hFFFFFFFF, `DEST_RESET);
    apb(1'b0, 12'h028, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, erv});
    chk("unmapped data", 32'h0, rdv);
    fm_u.ev(6'h08, 8'h5A, 2'b00);
    wait2();
    rchk("connected", `STATUS_OFF, 32'h10, 32'h10);
    fm_u.ev(6'h10, 8'h5A, 2'b00);
    wait2();
    rchk("busy", `STATUS_OFF, 32'h50, 32'h40);
    apb(1'b1, `CTRL_OFF, 32'h41A);
    fm_u.ev(6'h08, 8'hC3, 2'b00);
    wait2();
    rchk("caller", `STATUS_OFF, 32'hFF10, 32'hC300);
    chk("rejects", 32'h1, 32'(n_rej));
    apb(1'b1, `CTRL_OFF, 32'h418);
    fm_u.ev(6'h20, 8'h00, 2'b00);
    wait2();
    chk("relay off", 32'h0, 32'(n_relay));
    rchk("relayed", `STATUS_OFF, 32'h20, 32'h0);
    apb(1'b1, `CTRL_OFF, 32'h41A);
    fm_u.ev(6'h20, 8'h00, 2'b00);
    wait2();
    chk("relay on", 32'h1, 32'(n_relay));
    rchk("relayed", `STATUS_OFF, 32'h20, 32'h20);
    apb(1'b1, `CTRL_OFF, 32'h50A);
    apb(1'b1, `TXDATA_OFF, 32'h141);
    t0 = n_key;
    repeat (100) @(posedge pclk);
    chk("keyed", 32'h0, 32'(n_key - t0));
    send(32'h41A, 32'h80, 27'h0, 0, 32'h41, 1);
    send(32'h41A, 32'h80, {9'h10D, 9'h042}, 2, 32'h42, 1);
    fm_u.lag = 9;
    send(32'h71A, 32'h80, {9'h143, 9'h00D}, 2, 32'h430A0D, 3);
    send(32'h41A, 32'h3, {9'h033, 9'h032, 9'h031}, 3, 32'h333231, 3);
    send(32'h49A, 32'h2, {9'h035, 9'h034}, 2, 32'h3534, 2);
    apb(1'b1, `CTRL_OFF, 32'h241A);
    t0 = n_term;
    fm_u.ev(6'h01, 8'h55, 2'b00);
    repeat (20) @(posedge pclk);
    chk("held", 32'h0, 32'(n_term - t0));
    apb(1'b1, `CTRL_OFF, 32'h41A);
    repeat (20) @(posedge pclk);
    chk("delivered", 32'h1, 32'(n_term - t0));
    chk("term byte", 32'h55, {24'h0, last_term});
    apb(1'b1, `CTRL_OFF, 32'h141A);
    t0 = n_term;
    fm_u.ev(6'h01, 8'h5A, 2'b00);
    repeat (20) @(posedge pclk);
    chk("trace count", 32'h3, 32'(n_term - t0));
    chk("trace raw", 32'h5A, {24'h0, last_term});
    apb(1'b1, `CTRL_OFF, 32'hC1A);
    fm_u.ev(6'h02, 8'h00, 2'b01);
    repeat (4) @(posedge pclk);
    chk("bypass", 32'h1, 32'(n_facc));
    fm_u.ev(6'h02, 8'h00, 2'b00);
    repeat (4) @(posedge pclk);
    chk("partial", 32'h1, 32'(n_facc));
    conclude();
  end
endmodule // packet_link_tx_controller_tb
`default_nettype wire
